//--- crmp_map.svh
// constants for the configuration register message port
`ifndef CRMP_MAP_SVH
`define CRMP_MAP_SVH
`define CRMP_CT_WRITE 8'hc0
`define CRMP_CT_READ 8'hc1
`define CRMP_CT_END 8'h01
`define CRMP_CT_ACK 8'h03
`define CRMP_CT_NACK 8'h04
`define CRMP_NOREPLY_LOW 8'hff
`define CRMP_PS_RES_TYPE 8'h0b
`define CRMP_PS_SHIFT 8
`define CRMP_RET_BYTES 3'd3
`define CRMP_REG_BYTES 3'd2
`define CRMP_DATA_BYTES 3'd4
`define CRMP_REG_RESET 32'h00000000
`endif

//--- crmp_peer.sv
// remote channel-end model: request sender and stalling reply sink
`timescale 1ns/1ns
`include "crmp_map.svh"
module crmp_peer (
    input wire logic i_clk,
    input wire logic i_rx_ready,
    input wire logic i_slow,
    output logic o_rx_valid,
    output logic o_rx_ctrl,
    output logic [7:0] o_rx_data,
    output logic o_tx_ready
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_ctrl = 1'b0;
        o_rx_data = 8'h00;
        o_tx_ready = 1'b1;
    end

    // token held until taken
    task automatic send(input logic c, input logic [7:0] d);
        o_rx_valid <= 1'b1;
        o_rx_ctrl <= c;
        o_rx_data <= d;
        do @(posedge i_clk); while (i_rx_ready !== 1'b1);
    endtask

    // released data line shows no stale token
    task automatic idle();
        o_rx_valid <= 1'b0;
        o_rx_data <= ~o_rx_data;
        @(posedge i_clk);
    endtask

    task automatic request(input logic wr, input logic [23:0] ret, input logic [15:0] rn,
                           input logic [31:0] wd);
        send(1'b1, wr ? `CRMP_CT_WRITE : `CRMP_CT_READ);
        for (int i = 2; i >= 0; i--) send(1'b0, ret[i*8 +: 8]);
        for (int i = 1; i >= 0; i--) send(1'b0, rn[i*8 +: 8]);
        if (wr) for (int i = 3; i >= 0; i--) send(1'b0, wd[i*8 +: 8]);
        send(1'b1, `CRMP_CT_END);
        idle();
    endtask

    // stalling reply sink
    always @(posedge i_clk) begin
        o_tx_ready <= i_slow ? ($urandom_range(0, 2) == 0) : 1'b1;
    end
endmodule

//--- crmp_pkg.sv
// types for the configuration register message port
`include "crmp_map.svh"
package crmp_pkg;
    typedef logic [7:0] crmp_byte_t;
    typedef logic [31:0] crmp_word_t;
    typedef enum logic [1:0] {CRMP_OP_NONE, CRMP_OP_WRITE, CRMP_OP_READ} crmp_op_e;

    // processor-status register number to resource identifier
    function automatic logic [31:0] crmp_ps_resource(input logic [15:0] regnum);
        crmp_ps_resource = ({16'h0000, regnum} << `CRMP_PS_SHIFT) | 32'h0000000b;
    endfunction
endpackage

//--- crmp_port.sv
// configuration register message port: request parser and reply builder
`timescale 1ns/1ns
`include "crmp_map.svh"
module crmp_port #(
    parameter int ADDR_W = 4
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_rx_valid,
    input wire logic i_rx_ctrl,
    input wire crmp_pkg::crmp_byte_t i_rx_data,
    output logic o_rx_ready,
    output logic o_tx_valid,
    output logic o_tx_ctrl,
    output crmp_pkg::crmp_byte_t o_tx_data,
    output logic [23:0] o_tx_dest,
    input wire logic i_tx_ready,
    input wire logic [15:0] i_ps_regnum,
    output logic [31:0] o_ps_resource
);
    import crmp_pkg::*;

    typedef enum {ST_HEAD, ST_RET, ST_REG, ST_DATA, ST_END, ST_DRAIN, ST_EXEC, ST_RDWAIT,
        ST_REPLY} crmp_state_e;

    initial begin
        if (ADDR_W < 1 || ADDR_W > 12) $error("crmp_port: bad ADDR_W");
    end

    crmp_state_e state_r;
    crmp_op_e op_r;
    logic [2:0] cnt_r;
    logic [23:0] ret_r;
    logic [15:0] reg_r;
    logic [31:0] data_r;
    logic bad_r;
    logic [2:0] rcnt_r;
    logic ok_r;
    logic we;
    logic [31:0] rdata;

    // two-entry reply buffer
    logic [8:0] buf_r [0:1];
    logic [23:0] bdest_r [0:1];
    logic [1:0] bcount_r;
    logic bwr_r;
    logic brd_r;
    logic push;
    logic [8:0] push_tok;
    logic pop;

    function automatic logic reg_ok(input logic [15:0] r);
        reg_ok = (r < 16'(1 << ADDR_W));
    endfunction

    // ready is a register that tracks the parse states
    wire logic take = i_rx_valid && o_rx_ready;

    assign we = (state_r == ST_EXEC) && (op_r == CRMP_OP_WRITE) && !bad_r && reg_ok(reg_r);

    crmp_regbank #(.ADDR_W(ADDR_W), .DATA_W(32)) u_bank (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_we(we),
        .i_waddr(reg_r[ADDR_W-1:0]),
        .i_wdata(data_r),
        .i_raddr(reg_r[ADDR_W-1:0]),
        .o_rdata(rdata)
    );

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_r <= ST_HEAD;
            op_r <= CRMP_OP_NONE;
            cnt_r <= '0;
            ret_r <= '0;
            reg_r <= '0;
            data_r <= '0;
            bad_r <= 1'b0;
            rcnt_r <= '0;
            ok_r <= 1'b0;
            o_rx_ready <= 1'b1;
        end else begin
            case (state_r)
                ST_HEAD: if (take) begin
                    cnt_r <= '0;
                    bad_r <= 1'b0;
                    if (i_rx_ctrl && i_rx_data == `CRMP_CT_WRITE) begin
                        op_r <= CRMP_OP_WRITE;
                        state_r <= ST_RET;
                    end else if (i_rx_ctrl && i_rx_data == `CRMP_CT_READ) begin
                        op_r <= CRMP_OP_READ;
                        state_r <= ST_RET;
                    end
                end
                ST_RET: if (take) begin
                    ret_r <= {ret_r[15:0], i_rx_data};
                    if (i_rx_ctrl) bad_r <= 1'b1;
                    cnt_r <= cnt_r + 3'd1;
                    if (cnt_r == `CRMP_RET_BYTES - 3'd1) begin
                        cnt_r <= '0;
                        state_r <= ST_REG;
                    end
                end
                ST_REG: if (take) begin
                    reg_r <= {reg_r[7:0], i_rx_data};
                    if (i_rx_ctrl) bad_r <= 1'b1;
                    cnt_r <= cnt_r + 3'd1;
                    if (cnt_r == `CRMP_REG_BYTES - 3'd1) begin
                        cnt_r <= '0;
                        state_r <= (op_r == CRMP_OP_WRITE) ? ST_DATA : ST_END;
                    end
                end
                ST_DATA: if (take) begin
                    data_r <= {data_r[23:0], i_rx_data};
                    if (i_rx_ctrl) bad_r <= 1'b1;
                    cnt_r <= cnt_r + 3'd1;
                    if (cnt_r == `CRMP_DATA_BYTES - 3'd1) begin
                        cnt_r <= '0;
                        state_r <= ST_END;
                    end
                end
                ST_END: if (take) begin
                    if (!(i_rx_ctrl && i_rx_data == `CRMP_CT_END)) begin
                        bad_r <= 1'b1;
                        state_r <= i_rx_ctrl ? ST_EXEC : ST_DRAIN;
                        o_rx_ready <= !i_rx_ctrl;
                    end else begin
                        state_r <= ST_EXEC;
                        o_rx_ready <= 1'b0;
                    end
                end
                ST_DRAIN: if (take && i_rx_ctrl) begin
                    state_r <= ST_EXEC;
                    o_rx_ready <= 1'b0;
                end
                ST_EXEC: begin
                    ok_r <= !bad_r && reg_ok(reg_r);
                    rcnt_r <= '0;
                    if (op_r == CRMP_OP_WRITE && ret_r[7:0] == `CRMP_NOREPLY_LOW) begin
                        state_r <= ST_HEAD;
                        o_rx_ready <= 1'b1;
                    end else begin
                        state_r <= ST_RDWAIT;
                    end
                end
                ST_RDWAIT: state_r <= ST_REPLY;
                ST_REPLY: if (push) begin
                    rcnt_r <= rcnt_r + 3'd1;
                    if (push_tok == {1'b1, `CRMP_CT_END}) begin
                        state_r <= ST_HEAD;
                        o_rx_ready <= 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_HEAD;
                    o_rx_ready <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        push_tok = {1'b1, `CRMP_CT_END};
        if (rcnt_r == 3'd0) begin
            push_tok = ok_r ? {1'b1, `CRMP_CT_ACK} : {1'b1, `CRMP_CT_NACK};
        end else if (ok_r && op_r == CRMP_OP_READ && rcnt_r < 3'd5) begin
            push_tok = {1'b0, rdata[8*(4-int'(rcnt_r)) +: 8]};
        end
    end
    assign push = (state_r == ST_REPLY) && (bcount_r != 2'd2);
    assign pop = o_tx_valid && i_tx_ready;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            bcount_r <= '0;
            bwr_r <= 1'b0;
            brd_r <= 1'b0;
            buf_r[0] <= '0;
            buf_r[1] <= '0;
            bdest_r[0] <= '0;
            bdest_r[1] <= '0;
        end else begin
            if (push) begin
                buf_r[bwr_r] <= push_tok;
                bdest_r[bwr_r] <= ret_r;
                bwr_r <= ~bwr_r;
            end
            if (pop) brd_r <= ~brd_r;
            bcount_r <= bcount_r + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_tx_valid <= 1'b0;
            o_tx_ctrl <= 1'b0;
            o_tx_data <= '0;
            o_tx_dest <= '0;
        end else if (!o_tx_valid || i_tx_ready) begin
            o_tx_valid <= 1'b0;
            // head entry stays counted while it sits in the output register
            if (bcount_r > 2'(o_tx_valid)) begin
                o_tx_valid <= 1'b1;
                {o_tx_ctrl, o_tx_data} <= buf_r[brd_r ^ (o_tx_valid ? 1'b1 : 1'b0)];
                o_tx_dest <= bdest_r[brd_r ^ (o_tx_valid ? 1'b1 : 1'b0)];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_ps_resource <= '0;
        end else begin
            o_ps_resource <= crmp_ps_resource(i_ps_regnum);
        end
    end

    AST_NO_BAD_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_r == ST_EXEC && (bad_r || !reg_ok(reg_r))) |-> !we ##1 !ok_r)
        else $error("write with bad request");
    AST_SILENT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_r == ST_EXEC && op_r == CRMP_OP_WRITE && ret_r[7:0] == 8'hff)
        |=> state_r == ST_HEAD)
        else $error("silent write produced reply");
    // first reply token is ack or nack
    AST_FIRST_TOK: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (push && rcnt_r == 3'd0) |-> push_tok[8] &&
        (push_tok[7:0] == 8'h03 || push_tok[7:0] == 8'h04))
        else $error("bad first reply token");
    // ok write whose return low byte is not ff answers ack then end
    sequence s_write_ok;
        state_r == ST_EXEC && op_r == CRMP_OP_WRITE && !bad_r && reg_ok(reg_r) &&
            ret_r[7:0] != `CRMP_NOREPLY_LOW;
    endsequence
    sequence s_ack_end;
        ##[2:100] (push && push_tok == {1'b1, `CRMP_CT_ACK})
            ##[1:100] (push && push_tok == {1'b1, `CRMP_CT_END});
    endsequence
    AST_WRITE_REPLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_write_ok |-> s_ack_end)
        else $error("write reply sequence wrong");
    // read success carries four data bytes
    AST_READ_LEN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (push && rcnt_r == 3'd5) |-> push_tok == 9'h101)
        else $error("read reply length wrong");
    AST_WRITE_FIRST: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        we |=> state_r == ST_RDWAIT || state_r == ST_HEAD)
        else $error("write not before reply");
    AST_DEST: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        push |-> ##[1:300] (o_tx_valid && o_tx_dest == $past(ret_r)))
        else $error("reply destination lost");
    AST_PSRES: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_reset_n |=> o_ps_resource == {8'h00, $past(i_ps_regnum), 8'h0b})
        else $error("bad resource id");
    AST_MSB: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (take && state_r == ST_REG) |=>
        reg_r[7:0] == $past(i_rx_data) && reg_r[15:8] == $past(reg_r[7:0]))
        else $error("byte order wrong");
endmodule

//--- crmp_regbank.sv
// small register memory with registered read data
`timescale 1ns/1ns
module crmp_regbank #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 32
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_we,
    input wire logic [ADDR_W-1:0] i_waddr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [ADDR_W-1:0] i_raddr,
    output logic [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

    initial begin
        if (ADDR_W < 1 || ADDR_W > 12) $error("crmp_regbank: bad ADDR_W");
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int k = 0; k < (1<<ADDR_W); k++) begin
                mem_r[k] <= DATA_W'(`CRMP_REG_RESET);
            end
        end else if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_r[i_raddr];
        end
    end
endmodule

//--- tb_crmp_port.sv
// self-checking bench for the configuration register message port
`timescale 1ns/1ns
`include "crmp_map.svh"
module tb_crmp_port;
    import crmp_pkg::*;
    logic i_clk, i_reset_n, rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready;
    logic slow, run;
    crmp_byte_t rx_data, tx_data;
    logic [23:0] tx_dest;
    logic [15:0] ps_regnum, ps_next;
    logic [31:0] ps_res;
    logic [32:0] tok_q[$];
    logic [31:0] ps_q[$];
    crmp_word_t mem[16];
    int err_total, n_compared, cyc;

    crmp_port #(.ADDR_W(4)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_rx_valid(rx_valid), .i_rx_ctrl(rx_ctrl), .i_rx_data(rx_data),
        .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_ctrl(tx_ctrl),
        .o_tx_data(tx_data), .o_tx_dest(tx_dest), .i_tx_ready(tx_ready),
        .i_ps_regnum(ps_regnum), .o_ps_resource(ps_res));

    crmp_peer u_peer (.i_clk(i_clk), .i_rx_ready(rx_ready), .i_slow(slow),
        .o_rx_valid(rx_valid), .o_rx_ctrl(rx_ctrl), .o_rx_data(rx_data),
        .o_tx_ready(tx_ready));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic wrap_up();
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] exp, input logic [32:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask

    // notes the reply tokens, then sends the request
    task automatic access(input logic wr, input logic [23:0] ret, input logic [15:0] rn,
                          input logic [31:0] wd);
        logic ok;
        ok = (rn < 16);
        if (wr && ok) mem[rn[3:0]] = wd;
        if (!(wr && ret[7:0] == `CRMP_NOREPLY_LOW)) begin
            tok_q.push_back({ret, 1'b1, ok ? `CRMP_CT_ACK : `CRMP_CT_NACK});
            if (!wr && ok) begin
                for (int i = 3; i >= 0; i--) tok_q.push_back({ret, 1'b0, mem[rn[3:0]][i*8 +: 8]});
            end
            tok_q.push_back({ret, 1'b1, `CRMP_CT_END});
        end
        u_peer.request(wr, ret, rn, wd);
    endtask

    // malformed requests after a stray token: nack, bank untouched
    task automatic broken(input logic wr, input logic [23:0] ret, input logic [15:0] rn);
        tok_q.push_back({ret, 1'b1, `CRMP_CT_NACK});
        tok_q.push_back({ret, 1'b1, `CRMP_CT_END});
        u_peer.send(1'b0, 8'($urandom));
        u_peer.send(1'b1, wr ? `CRMP_CT_WRITE : `CRMP_CT_READ);
        for (int i = 2; i >= 0; i--) u_peer.send(1'b0, ret[i*8 +: 8]);
        if (wr) begin
            for (int i = 1; i >= 0; i--) u_peer.send(1'b0, rn[i*8 +: 8]);
            for (int i = 0; i < 6; i++) u_peer.send(1'b0, 8'($urandom));
        end else begin
            u_peer.send(1'b1, rn[15:8]);
            u_peer.send(1'b0, rn[7:0]);
        end
        u_peer.send(1'b1, `CRMP_CT_END);
        u_peer.idle();
    endtask

    function automatic logic [23:0] any_ret();
        any_ret = {16'($urandom), 8'($urandom_range(0, 254))};
    endfunction

    always @(posedge i_clk) begin
        if (i_reset_n === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (tok_q.size() == 0) begin
                check({33{1'bx}}, {tx_dest, tx_ctrl, tx_data});
            end else begin
                check(tok_q.pop_front(), {tx_dest, tx_ctrl, tx_data});
            end
        end
    end

    always @(posedge i_clk) begin
        if (run) begin
            ps_next = 16'($urandom);
            ps_regnum <= ps_next;
            ps_q.push_back(({16'h0000, ps_next} << 8) | 32'h0000000b);
        end
    end

    always @(negedge i_clk) begin
        if (ps_q.size() > 1) check({1'b0, ps_q.pop_front()}, {1'b0, ps_res});
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(28755));
        i_reset_n = 1'b0;
        slow = 1'b0;
        run = 1'b0;
        ps_regnum = 16'h0000;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        run <= 1'b1;
        @(posedge i_clk);
        for (int i = 0; i < 16; i++) access(1'b1, any_ret(), 16'(i), $urandom);
        slow <= 1'b1;
        for (int i = 15; i >= 0; i--) access(1'b0, any_ret(), 16'(i), 32'h0);
        access(1'b1, {16'($urandom), 8'hff}, 16'h0003, $urandom);
        access(1'b0, any_ret(), 16'h0003, 32'h0);
        access(1'b1, any_ret(), 16'h0010, $urandom);
        access(1'b1, any_ret(), 16'hff05, $urandom);
        access(1'b0, any_ret(), 16'h0010, 32'h0);
        access(1'b1, 24'h1234ff, 16'h0020, $urandom);
        broken(1'b1, any_ret(), 16'h0006);
        broken(1'b0, any_ret(), 16'h0002);
        access(1'b0, any_ret(), 16'h0006, 32'h0);
        slow <= 1'b0;
        access(1'b0, any_ret(), 16'h0005, 32'h0);
        while (tok_q.size() != 0) @(posedge i_clk);
        repeat (4) @(posedge i_clk);
        wrap_up();
    end
endmodule
